// ---- verilog/bpp_top.sv ----
/*
 * port pin block: data latches, direction and pull-up controls for seven
 * byte-wide ports, pin drivers with peripheral override, cpu read path.
 * assumes a synchronous cpu bus on clk and external pins resolved by the bench.
 */
`default_nettype none

module bpp_top
	import bpp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [bpp_pkg::AW-1:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_we,
	input wire logic cpu_re,
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	input wire logic [bpp_pkg::NPORT-1:0][7:0] pin_i,
	output logic [bpp_pkg::NPORT-1:0][7:0] pin_o,
	output logic [bpp_pkg::NPORT-1:0][7:0] pin_oe,
	output logic [bpp_pkg::NPORT-1:0][7:0] pullup_en,
	input wire logic [bpp_pkg::NPORT-1:0][7:0] periph_sel,
	input wire logic [bpp_pkg::NPORT-1:0][7:0] periph_o,
	input wire logic [bpp_pkg::NPORT-1:0][7:0] periph_oe,
	output logic [bpp_pkg::NPORT-1:0][7:0] periph_i
);
	import bpp_pkg::*;

	logic [NPORT-1:0][7:0] latch_q;
	logic [NPORT-1:0][7:0] dir_q;
	logic [NPORT-1:0][7:0] pin_s;
	logic port_hit;
	logic pull_hit;
	logic is_dir;
	logic [2:0] port_idx;
	logic [2:0] pull_idx;
	logic [7:0] rdata_d;

	// ****************************************
	// address decode
	// ****************************************
	// even address is data, odd is direction
	assign port_hit = (cpu_addr >= ADDR_PORT_BASE) && (cpu_addr <= ADDR_PORT_END);
	assign port_idx = cpu_addr[3:1];
	assign is_dir = cpu_addr[0];
	// separate range for pull-ups
	assign pull_hit = (cpu_addr >= ADDR_PULL_BASE) && (cpu_addr <= ADDR_PULL_END);
	assign pull_idx = cpu_addr[2:0];

	// ****************************************
	// data latches: written whatever the direction
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			latch_q <= {NPORT{LATCH_RST}};
		end else if (ce && cpu_we && port_hit && !is_dir) begin
			latch_q[port_idx] <= cpu_wdata; // latch only, the driver flops pick it up on the next clock
		end
	end

	// ****************************************
	// direction registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dir_q <= {NPORT{DIR_RST}}; // all inputs after reset
		end else if (ce && cpu_we && port_hit && is_dir) begin
			dir_q[port_idx] <= cpu_wdata; // one bit per pin
		end
	end

	// ****************************************
	// pull-up control registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pullup_en <= {NPORT{PULL_RST}};
		end else if (ce && cpu_we && pull_hit) begin
			pullup_en[pull_idx] <= cpu_wdata;
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdata_d = RDATA_RST; // unmapped reads give zero
		if (port_hit && is_dir) begin
			rdata_d = dir_q[port_idx];
		end else if (port_hit) begin
			// output pins show the latch, inputs the pin
			rdata_d = (latch_q[port_idx] & dir_q[port_idx]) |
				(pin_s[port_idx] & ~dir_q[port_idx]);
		end else if (pull_hit) begin
			rdata_d = pullup_en[pull_idx];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cpu_rdata <= RDATA_RST;
			cpu_rvalid <= 1'b0;
		end else if (ce) begin
			cpu_rvalid <= cpu_re;
			if (cpu_re) begin
				cpu_rdata <= rdata_d;
			end
		end
	end

	// ****************************************
	// per-port pin logic
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_port
			logic [7:0] src_o;
			logic [7:0] src_oe;
			logic [7:0] odm;

			bpp_sync u_sync (
				.clk(clk),
				.nrst(nrst),
				.ce(ce),
				.d(pin_i[g]),
				.q(pin_s[g])
			);

			assign odm = (g == OD_PORT) ? OD_MASK : NO_MASK;
			// peripheral takes over selected pins
			assign src_o = (periph_sel[g] & periph_o[g]) | (~periph_sel[g] & latch_q[g]);
			// dir 1 drives, dir 0 leaves the pin floating
			assign src_oe = (periph_sel[g] & periph_oe[g]) | (~periph_sel[g] & dir_q[g]);

			// driver flops; open-drain bit drives only a low
			always_ff @(posedge clk) begin
				if (!nrst) begin
					pin_o[g] <= 8'h00;
					pin_oe[g] <= 8'h00;
					periph_i[g] <= 8'h00;
				end else if (ce) begin
					pin_o[g] <= src_o & ~odm;
					pin_oe[g] <= (src_oe & ~odm) | (src_oe & ~src_o & odm);
					periph_i[g] <= pin_s[g];
				end
			end
		end
	endgenerate

	// ****************************************
	// assertions
	// ****************************************
	sequence s_dir_wr;
		ce && cpu_we && port_hit && is_dir;
	endsequence

	sequence s_wr_input;
		ce && cpu_we && port_hit && !is_dir && dir_q[port_idx] == 8'h00 &&
			periph_sel[port_idx] == 8'h00 ##1 !cpu_we;
	endsequence

	property p_dir_write;
		@(posedge clk) disable iff (!nrst)
		s_dir_wr |=> dir_q[$past(port_idx)] == $past(cpu_wdata);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write lost");

	property p_out_drive;
		@(posedge clk) disable iff (!nrst)
		ce |=> ((pin_oe[0] ^ $past(dir_q[0])) & ~$past(periph_sel[0])) == 8'h00;
	endproperty
	a_out_drive: assert property (p_out_drive) else $error("enable differs from direction");

	property p_read_mux;
		@(posedge clk) disable iff (!nrst)
		ce && cpu_re && port_hit && !is_dir |=> cpu_rvalid &&
			cpu_rdata == (($past(latch_q[port_idx]) & $past(dir_q[port_idx])) |
			($past(pin_s[port_idx]) & ~$past(dir_q[port_idx])));
	endproperty
	a_read_mux: assert property (p_read_mux) else $error("port read value wrong");

	property p_in_float;
		@(posedge clk) disable iff (!nrst)
		ce |=> (pin_oe[5] & ~$past(dir_q[5]) & ~$past(periph_sel[5])) == 8'h00;
	endproperty
	a_in_float: assert property (p_in_float) else $error("input pin driven");

	property p_wr_input;
		@(posedge clk) disable iff (!nrst)
		s_wr_input |=> pin_oe[$past(port_idx, 2)] == 8'h00 &&
			latch_q[$past(port_idx, 2)] == $past(cpu_wdata, 2);
	endproperty
	a_wr_input: assert property (p_wr_input) else $error("input write moved driver");

	property p_od_low;
		@(posedge clk) disable iff (!nrst)
		ce |=> !pin_o[OD_PORT][OD_BIT] &&
			pin_oe[OD_PORT][OD_BIT] == ($past(g_port[OD_PORT].src_oe[OD_BIT]) &&
			!$past(g_port[OD_PORT].src_o[OD_BIT]));
	endproperty
	a_od_low: assert property (p_od_low) else $error("open-drain pin drove high");

	property p_periph;
		@(posedge clk) disable iff (!nrst)
		ce |=> ((pin_o[5] ^ $past(periph_o[5])) & $past(periph_sel[5])) == 8'h00 &&
			((pin_oe[5] ^ $past(periph_oe[5])) & $past(periph_sel[5])) == 8'h00;
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral override ignored");

	property p_pull_write;
		@(posedge clk) disable iff (!nrst)
		ce && cpu_we && pull_hit |=> pullup_en[$past(pull_idx)] == $past(cpu_wdata);
	endproperty
	a_pull_write: assert property (p_pull_write) else $error("pull-up write lost");

	property p_reset_in;
		@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> dir_q == '0 && pin_oe == '0;
	endproperty
	a_reset_in: assert property (p_reset_in) else $error("pin not input after reset");
endmodule

`default_nettype wire

// ---- verilog/bpp_pkg.sv ----
/*
 * constants for the bidirectional port pin block: port count, address map,
 * reset values and the position of the open-drain pin.
 * assumes a byte-wide cpu special-function-register bus with 12-bit addresses.
 */
`default_nettype none

package bpp_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int NPORT = 7;
	localparam int PW = 8;
	localparam int AW = 12;
	typedef logic [PW-1:0] bpp_byte_t;

	// ****************************************
	// address map
	// ****************************************
	localparam logic [AW-1:0] ADDR_PORT_BASE = 12'h000; // data even, direction odd
	localparam logic [AW-1:0] ADDR_PORT_END = 12'h00d;
	localparam logic [AW-1:0] ADDR_PULL_BASE = 12'hff0; // pull-up controls
	localparam logic [AW-1:0] ADDR_PULL_END = 12'hff6;

	// ****************************************
	// reset values
	// ****************************************
	localparam bpp_byte_t DIR_RST = 8'h00;
	localparam bpp_byte_t LATCH_RST = 8'h00;
	localparam bpp_byte_t PULL_RST = 8'h00;
	localparam bpp_byte_t RDATA_RST = 8'h00;

	// ****************************************
	// open-drain pin position
	// ****************************************
	localparam int OD_PORT = 3;
	localparam int OD_BIT = 3;
	localparam bpp_byte_t OD_MASK = 8'h08;
	localparam bpp_byte_t NO_MASK = 8'h00;
endpackage

`default_nettype wire

// ---- verilog/bpp_sync.sv ----
/*
 * two-flop synchroniser for one byte of pin levels.
 * assumes the inputs are asynchronous pins; the first stage feeds only the second.
 */
`default_nettype none

module bpp_sync (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [7:0] d,
	output logic [7:0] q
);
	logic [7:0] meta_q;

	// ****************************************
	// two stages, frozen while ce is low
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_q <= 8'h00;
			q <= 8'h00;
		end else if (ce) begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

`default_nettype wire

// ---- tb/bpp_far.sv ----
/*
 * far side of the port pins: resolves each pin level from the block's
 * drivers, the pull-ups and an outside source set by the bench.
 * assumes one outside source per pin, weaker than any enabled driver.
 */
`default_nettype none

module bpp_far (
	input wire logic [bpp_pkg::NPORT-1:0][7:0] pin_o,
	input wire logic [bpp_pkg::NPORT-1:0][7:0] pin_oe,
	input wire logic [bpp_pkg::NPORT-1:0][7:0] pullup_en,
	input wire logic [bpp_pkg::NPORT-1:0][7:0] ext,
	output logic [bpp_pkg::NPORT-1:0][7:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ns;
	import bpp_pkg::*;
	// *****************
	// pin resolution
	// *****************
	// driven pins show the driver, released ones the pull-up or the source
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & (pullup_en | ext));
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
/*
 * bench for bpp_top: random direction and latch setup per port, readback,
 * pin drivers, open-drain pin, pull-ups, peripheral override.
 * assumes bpp_far models the outside of the pins.
 */
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import bpp_pkg::*;
	// *****************
	// signals
	// *****************
	logic clk = 0;
	logic nrst = 0;
	logic we = 0;
	logic ce = 1;
	logic re = 0;
	logic rv;
	logic [AW-1:0] ad = '0;
	logic [7:0] wd = '0;
	logic [7:0] rdat;
	logic [7:0] e;
	logic [NPORT-1:0][7:0] pi, po, poe, pu, pvi;
	logic [NPORT-1:0][7:0] ps = '0;
	logic [NPORT-1:0][7:0] pvo = '0;
	logic [NPORT-1:0][7:0] pvoe = '0;
	logic [NPORT-1:0][7:0] ext = '0;
	logic [7:0] dr [NPORT];
	logic [7:0] lt [NPORT];
	logic [7:0] q [$];
	int failures = 0;
	int cmp_count = 0;
	int seed = 43;
	int cyc = 0;

	bpp_top i_bpp_top (.clk(clk), .nrst(nrst), .ce(ce), .cpu_addr(ad), .cpu_wdata(wd),
		.cpu_we(we), .cpu_re(re), .cpu_rdata(rdat), .cpu_rvalid(rv), .pin_i(pi),
		.pin_o(po), .pin_oe(poe), .pullup_en(pu), .periph_sel(ps), .periph_o(pvo),
		.periph_oe(pvoe), .periph_i(pvi));
	bpp_far i_bpp_far (.pin_o(po), .pin_oe(poe), .pullup_en(pu), .ext(ext), .pin_i(pi));

	// *****************
	// tasks
	// *****************
	initial begin
		forever #20 clk = ~clk;
	end

	task chk(input string n, input logic [55:0] x, input logic [55:0] g);
		cmp_count++;
		if (g !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask

	task wr(input logic [AW-1:0] a, input logic [7:0] d);
		@(negedge clk);
		ad = a;
		wd = d;
		we = 1;
		@(negedge clk);
		we = 0;
	endtask

	// read request, expected data noted for the watcher
	task rd(input logic [AW-1:0] a, input logic [7:0] x);
		@(negedge clk);
		ad = a;
		re = 1;
		q.push_back(x);
		@(negedge clk);
		re = 0;
	endtask

	task pins(input int p, input logic [7:0] eo, input logic [7:0] eoe);
		chk("pin_oe", eoe, poe[p]);
		chk("pin_o", eo & eoe, po[p] & eoe);
	endtask

	task print_verdict();
		chk("reads_left", 56'h0, 56'(q.size()));
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// *****************
	// watcher and timeout
	// *****************
	always @(posedge clk) begin
		if (rv === 1'b1) chk("rdata", q.pop_front(), rdat);
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			print_verdict();
		end
	end

	// *****************
	// main sequence
	// *****************
	initial begin
		repeat (10) @(negedge clk);
		nrst = 1;
		@(negedge clk);
		chk("oe_rst", '0, poe);
		chk("pu_rst", '0, pu);
		for (int p = 0; p < NPORT; p++) begin
			dr[p] = 8'($random(seed));
			lt[p] = 8'($random(seed));
			ext[p] = 8'($random(seed));
			// latch written while the port is still all inputs
			wr(AW'(2 * p), lt[p]);
			chk("oe_in", 8'h00, poe[p]);
			wr(AW'(2 * p + 1), dr[p]);
			repeat (3) @(negedge clk);
			e = dr[p];
			if (p == OD_PORT) e[OD_BIT] = dr[p][OD_BIT] & ~lt[p][OD_BIT];
			pins(p, (p == OD_PORT) ? lt[p] & ~OD_MASK : lt[p], e);
			rd(AW'(2 * p), (lt[p] & dr[p]) | (ext[p] & ~dr[p]));
			rd(AW'(2 * p + 1), dr[p]);
		end
		rd(12'h00e, 8'h00);
		e = 8'($random(seed));
		wr(ADDR_PULL_BASE + 12'h002, e);
		repeat (3) @(negedge clk);
		chk("pullup", e, pu[2]);
		rd(12'h004, (lt[2] & dr[2]) | ((ext[2] | e) & ~dr[2]));
		ps[5] = 8'h0f;
		pvo[5] = 8'($random(seed));
		pvoe[5] = 8'h05;
		repeat (2) @(negedge clk);
		pins(5, (pvo[5] & 8'h0f) | (lt[5] & 8'hf0), 8'h05 | (dr[5] & 8'hf0));
		chk("periph_i", (lt[6] & dr[6]) | (ext[6] & ~dr[6]), pvi[6]);
		// a write while ce is low must not be taken
		ce = 0;
		wr(12'h001, ~dr[0]);
		ce = 1;
		rd(12'h001, dr[0]);
		repeat (3) @(negedge clk);
		print_verdict();
	end
endmodule

`default_nettype wire
